// File: hw/uart_rx_defs.svh
// Constants for the asynchronous receive front end
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

// Register byte offsets
`define RX_DATA_OFS 4'h0
`define RX_STATUS_OFS 4'h4
`define RX_CTRL_OFS 4'h8
`define RX_BAUD_OFS 4'hC

// Status field positions
`define ST_COMPLETE_BIT 0
`define ST_FRAME_ERR_BIT 1
`define ST_OVERRUN_BIT 2
`define ST_BUSY_BIT 3

// Control field positions
`define CT_ENABLE_BIT 0
`define CT_DOUBLE_BIT 1
`define CT_LEN_LSB 4
`define CT_LEN_MSB 7

// Reset values
`define CTRL_RESET 8'h80
`define BAUD_RESET 16'h0019

// Oversampling figures and frame length range
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define VOTE_FIRST_NORMAL 5'h08
`define VOTE_FIRST_DOUBLE 5'h04
`define LEN_MIN 4'h5
`define LEN_MAX 4'hA

`endif

// File: hw/uart_rx_pkg.sv
// Types shared by the receive front end
package uart_rx_pkg;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_BITS = 3'b011,
        RX_STOP = 3'b010
    } rx_state_t;
endpackage : uart_rx_pkg

// File: hw/rx_line_sync.sv
// Two-flop synchroniser for the serial receive line
`timescale 1ns/1ps
module rx_line_sync (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic line_in,
    output logic line_out
);
    logic meta_r;

    // Idle-high line passes two flops before use
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b1;
            line_out <= 1'b1;
        end else begin
            meta_r <= line_in;
            line_out <= meta_r;
        end
    end
endmodule : rx_line_sync

// File: hw/sample_tick_gen.sv
// Divider producing one-cycle oversampling enable pulses
`timescale 1ns/1ps
module sample_tick_gen #(
    parameter int DIV_W = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [DIV_W-1:0] baud_divisor_value,
    output logic tick
);
    logic [DIV_W-1:0] count_r;

    // Count down the divisor, pulse at zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (count_r == '0) begin
            count_r <= baud_divisor_value;
            tick <= 1'b1;
        end else begin
            count_r <= count_r - 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : sample_tick_gen

// File: hw/uart_async_rx_recovery.sv
// Asynchronous receive front end with Avalon-MM registers
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "uart_rx_defs.svh"
module uart_async_rx_recovery #(
    parameter int DEPTH = 2,
    parameter int DIV_W = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic serial_receive_line,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response
);
    import uart_rx_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic line_s;
    logic line_d_r;
    logic tick;
    logic [7:0] ctrl_r;
    logic [DIV_W-1:0] baud_r;
    logic rx_enable;
    logic double_speed_select;
    logic [3:0] frame_len;
    logic [4:0] states_per_bit;
    logic [4:0] vote_first;
    rx_state_t state_r;
    logic [4:0] phase_r;
    logic [3:0] bit_cnt_r;
    logic [2:0] votes_r;
    logic [9:0] shift_r;
    logic [10:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;
    logic overrun_r;
    logic vote;
    logic last_vote;
    logic bus_req;
    logic hit;
    logic data_rd;

    assign rx_enable = ctrl_r[`CT_ENABLE_BIT];
    assign double_speed_select = ctrl_r[`CT_DOUBLE_BIT];
    assign frame_len = ctrl_r[`CT_LEN_MSB:`CT_LEN_LSB];

    // ----------------------------------------------------------------
    // Line synchroniser and sample clock
    // ----------------------------------------------------------------
    rx_line_sync u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .line_in(serial_receive_line),
        .line_out(line_s)
    );

    sample_tick_gen #(.DIV_W(DIV_W)) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .baud_divisor_value(baud_r),
        .tick(tick)
    );

    // Speed select changes states per bit and voting window
    always_comb begin
        if (double_speed_select) begin
            states_per_bit = `OVS_DOUBLE;
            vote_first = `VOTE_FIRST_DOUBLE;
        end else begin
            states_per_bit = `OVS_NORMAL;
            vote_first = `VOTE_FIRST_NORMAL;
        end
    end

    // Majority of the two stored samples and the current one
    assign vote = (votes_r[0] & votes_r[1]) | (votes_r[0] & line_s)
        | (votes_r[1] & line_s);
    // Voting around the bit centre sets the tolerated rate mismatch
    assign last_vote = tick && (phase_r == vote_first + 5'd2);

    // ----------------------------------------------------------------
    // Clock and data recovery
    // ----------------------------------------------------------------
    // Previous sampled level for falling edge detection
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            line_d_r <= 1'b1;
        end else if (tick) begin
            line_d_r <= line_s;
        end
    end

    // Receive state machine: start hunt, bits, first stop
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= RX_IDLE;
            phase_r <= 5'd0;
            bit_cnt_r <= 4'd0;
            votes_r <= 3'b111;
            shift_r <= 10'd0;
        end else if (!rx_enable) begin
            state_r <= RX_IDLE;
            phase_r <= 5'd0;
        end else if (tick) begin
            case (state_r)
                RX_IDLE: begin
                    if (line_d_r && !line_s) begin
                        state_r <= RX_START;
                        phase_r <= 5'd2;
                    end
                end
                RX_START: begin
                    phase_r <= phase_r + 5'd1;
                    if (phase_r == vote_first) begin
                        votes_r[0] <= line_s;
                    end
                    if (phase_r == vote_first + 5'd1) begin
                        votes_r[1] <= line_s;
                    end
                    if (last_vote) begin
                        if (vote) begin
                            state_r <= RX_IDLE;
                        end
                    end
                    if (phase_r == states_per_bit) begin
                        phase_r <= 5'd1;
                        bit_cnt_r <= 4'd0;
                        state_r <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    phase_r <= phase_r + 5'd1;
                    if (phase_r == vote_first) begin
                        votes_r[0] <= line_s;
                    end
                    if (phase_r == vote_first + 5'd1) begin
                        votes_r[1] <= line_s;
                    end
                    if (last_vote) begin
                        shift_r <= {vote, shift_r[9:1]};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                    end
                    if (phase_r == states_per_bit) begin
                        phase_r <= 5'd1;
                        if (bit_cnt_r == frame_len) begin
                            state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    phase_r <= phase_r + 5'd1;
                    if (phase_r == vote_first) begin
                        votes_r[0] <= line_s;
                    end
                    if (phase_r == vote_first + 5'd1) begin
                        votes_r[1] <= line_s;
                    end
                    if (last_vote) begin
                        state_r <= RX_IDLE;
                    end
                end
                default: begin
                    state_r <= RX_IDLE;
                end
            endcase
        end
    end

    // Stop vote hands the character to the buffer
    assign push = rx_enable && state_r == RX_STOP && last_vote;

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    assign pop = data_rd && count_r != '0;

    // Storage: right aligned data and stop-error flag
    // The stop vote is taken from the live majority in the push cycle
    always_ff @(posedge sys_clk) begin
        if (push && count_r != (PW+1)'(DEPTH)) begin
            mem_r[wr_ptr_r] <= {!vote,
                10'(shift_r >> (4'd10 - frame_len))};
        end
    end

    // Pointers and occupancy, flushed when disabled
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (!rx_enable) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push && count_r != (PW+1)'(DEPTH)) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            case ({push && count_r != (PW+1)'(DEPTH), pop})
                2'b10: count_r <= count_r + 1'b1;
                2'b01: count_r <= count_r - 1'b1;
                default: count_r <= count_r;
            endcase
        end
    end

    // Overrun: frame lost because the buffer was full
    // Sticky until the receiver is disabled; a push that meets a full
    // buffer is dropped even when a read pops in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            overrun_r <= 1'b0;
        end else if (!rx_enable) begin
            overrun_r <= 1'b0;
        end else if (push && count_r == (PW+1)'(DEPTH)) begin
            overrun_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    assign bus_req = (avs_read || avs_write) && avs_waitrequest;
    assign hit = avs_address == `RX_DATA_OFS || avs_address == `RX_STATUS_OFS
        || avs_address == `RX_CTRL_OFS || avs_address == `RX_BAUD_OFS;
    assign data_rd = bus_req && avs_read && avs_address == `RX_DATA_OFS;

    // One wait state: waitrequest drops for one cycle per access
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !bus_req;
        end
    end

    // Control and divisor registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `CTRL_RESET;
            baud_r <= DIV_W'(`BAUD_RESET);
        end else if (bus_req && avs_write) begin
            if (avs_address == `RX_CTRL_OFS && avs_byteenable[0]) begin
                ctrl_r <= avs_writedata[7:0];
            end
            if (avs_address == `RX_BAUD_OFS) begin
                baud_r <= DIV_W'(avs_writedata[15:0]);
            end
        end
    end

    // Read data and response
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (bus_req) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= hit ? 2'b00 : 2'b11;
            if (avs_read) begin
                case (avs_address)
                    `RX_DATA_OFS: begin
                        if (count_r != '0) begin
                            avs_readdata[9:0] <= mem_r[rd_ptr_r][9:0];
                        end
                    end
                    `RX_STATUS_OFS: begin
                        avs_readdata[`ST_COMPLETE_BIT] <= count_r != '0;
                        avs_readdata[`ST_FRAME_ERR_BIT] <=
                            count_r != '0 && mem_r[rd_ptr_r][10];
                        avs_readdata[`ST_OVERRUN_BIT] <= overrun_r;
                        avs_readdata[`ST_BUSY_BIT] <= state_r != RX_IDLE;
                    end
                    `RX_CTRL_OFS: avs_readdata[7:0] <= ctrl_r;
                    `RX_BAUD_OFS: avs_readdata[DIV_W-1:0] <= baud_r;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : uart_async_rx_recovery

// File: testbench/uart_async_rx_recovery_assertions.sv
// Bus and flush checker for the receive front end
`timescale 1ns/1ps
module uart_rx_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response
);
    logic req;
    logic mapped;
    logic off_r;
    // Request seen and address decode
    assign req = (avs_read | avs_write) & avs_waitrequest;
    assign mapped = (avs_address[1:0] == 2'h0);
    // Receiver disabled since last control write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            off_r <= 1'b1;
        end else if (req && avs_write && avs_address == 4'h8 && avs_byteenable[0]) begin
            off_r <= !avs_writedata[0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_answer_next: assert property (req |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_no_answer: assert property (!(avs_read | avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_err: assert property (req && !mapped |=>
        avs_response == 2'b11 && avs_readdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (req && mapped |=> avs_response == 2'b00)
        else $error("mapped access refused");
    a_data_upper: assert property (req && avs_read && avs_address == 4'h0 |=>
        avs_readdata[31:10] == 22'h0)
        else $error("data upper bits not zero");
    a_flush_status: assert property (req && avs_read && avs_address == 4'h4 && off_r |=>
        avs_readdata[3:0] == 4'h0)
        else $error("status not clear while disabled");
    a_flush_data: assert property (req && avs_read && avs_address == 4'h0 && off_r |=>
        avs_readdata == 32'h0000_0000)
        else $error("data present while disabled");
endmodule : uart_rx_checker
bind uart_async_rx_recovery uart_rx_checker chk (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response));

// File: testbench/serial_tx_model.sv
// Remote asynchronous transmitter model on the receive line
`timescale 1ns/1ps
module serial_tx_model (
    input wire logic sys_clk,
    output logic line
);
    // Idle level is high
    initial line = 1'b1;
    // Frame sender; bit length in clocks sets the rate error
    task automatic send(input logic [9:0] d, input int len, input logic stop,
        input int bclk, input int sclk);
        line <= 1'b0;
        repeat (bclk) @(posedge sys_clk);
        for (int i = 0; i < len; i++) begin
            line <= d[i];
            repeat (bclk) @(posedge sys_clk);
        end
        line <= stop;
        repeat (sclk) @(posedge sys_clk);
        line <= 1'b1;
    endtask : send
    // Short low pulse on the line
    task automatic glitch(input int n);
        line <= 1'b0;
        repeat (n) @(posedge sys_clk);
        line <= 1'b1;
    endtask : glitch
endmodule : serial_tx_model

// File: testbench/uart_async_rx_recovery_tb.sv
// Self-checking bench for the receive front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module uart_async_rx_recovery_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic line;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    always #12.5 sys_clk = ~sys_clk;
    serial_tx_model tx (.sys_clk(sys_clk), .line(line));
    uart_async_rx_recovery dut (.sys_clk(sys_clk), .resetn(resetn),
        .serial_receive_line(line), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));
    // ----------------------------------------
    // Bus and closing tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (n >= 50) errors++;
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // Receive one frame and check status, data, drained status
    task automatic rx_one(input logic [9:0] d, input int len, input logic stop,
        input int bclk, input logic [3:0] st);
        tx.send(d, len, stop, bclk, bclk);
        repeat (40) @(posedge sys_clk);
        bus(0, 4'h4, 0);
        `CHK("status", st, rd[3:0])
        bus(0, 4'h0, 0);
        `CHK("data", 32'(d & 10'((1 << len) - 1)), rd)
        bus(0, 4'h4, 0);
        `CHK("drained", 4'h0, rd[3:0])
    endtask : rx_one
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        bus(0, 4'h8, 0);
        `CHK("ctrl", 32'h0000_0080, rd)
        bus(0, 4'hC, 0);
        `CHK("divisor", 32'h0000_0019, rd)
        bus(0, 4'h2, 0);
        `CHK("unmapped", 2'b11, rsp)
        bus(1, 4'hC, 32'h0000_0001);
        `CHK("wr resp", 2'b00, rsp)
        $display("regs done");
    endtask : t_regs
    task automatic t_modes;
        int lens[3] = '{5, 8, 10};
        for (int m = 0; m < 2; m++) begin
            foreach (lens[i]) begin
                bus(1, 4'h8, 32'(lens[i] << 4 | m << 1 | 1));
                rx_one(10'h2A5 ^ 10'(lens[i]), lens[i], 1, m ? 16 : 32, 4'h1);
            end
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_err_rate;
        bus(1, 4'h8, 32'h0000_0081);
        rx_one(10'h0C3, 8, 0, 32, 4'h3);
        rx_one(10'h05A, 8, 1, 31, 4'h1);
        rx_one(10'h0A5, 8, 1, 33, 4'h1);
        tx.glitch(6);
        bus(0, 4'h4, 0);
        `CHK("hunt", 4'h8, rd[3:0])
        repeat (200) @(posedge sys_clk);
        bus(0, 4'h4, 0);
        `CHK("noise", 4'h0, rd[3:0])
        $display("error, rate, noise done");
    endtask : t_err_rate
    task automatic t_early_flush;
        tx.send(10'h011, 8, 1, 32, 24);
        tx.send(10'h0EE, 8, 1, 32, 32);
        repeat (40) @(posedge sys_clk);
        bus(0, 4'h4, 0);
        `CHK("two held", 4'h1, rd[3:0])
        bus(0, 4'h0, 0);
        `CHK("first", 32'h0000_0011, rd)
        bus(0, 4'h0, 0);
        `CHK("second", 32'h0000_00EE, rd)
        tx.send(10'h033, 8, 1, 32, 32);
        tx.send(10'h044, 8, 1, 32, 32);
        repeat (40) @(posedge sys_clk);
        bus(1, 4'h8, 32'h0000_0080);
        bus(0, 4'h4, 0);
        `CHK("flushed", 4'h0, rd[3:0])
        bus(1, 4'h8, 32'h0000_0081);
        bus(0, 4'h0, 0);
        `CHK("flush data", 32'h0000_0000, rd)
        $display("early start, flush done");
    endtask : t_early_flush
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        t_err_rate();
        t_early_flush();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
endmodule : uart_async_rx_recovery_tb
